// ===== inc/srpc_map.vh
`ifndef SRPC_MAP_VH
`define SRPC_MAP_VH
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define SRPC_OP_AND 4'h0
`define SRPC_OP_BIT_CLEAR 4'h1
`define SRPC_OP_OR 4'h2
`define SRPC_OP_XOR 4'h3
`define SRPC_OP_ADD 4'h4
`define SRPC_OP_SUB 4'h5
`define SRPC_OP_MUL 4'h6
`define SRPC_OP_INVERT 4'h7
`define SRPC_OP_LITERAL 4'h8
`define SRPC_OP_ROTATE 4'h9
`define SRPC_OP_COND_REG_LINK 4'ha
`define SRPC_OP_REG_JUMP 4'hb
`define SRPC_OP_LOAD 4'hc
`define SRPC_OP_STORE 4'hd
`define SRPC_OP_COND_BRANCH 4'he
`define SRPC_OP_BRANCH_LINK 4'hf
// ----------------------------------------
// Sizes and special values
// ----------------------------------------
`define SRPC_PC_W 12
`define SRPC_DADDR_W 11
`define SRPC_PMEM_DEPTH 4096
`define SRPC_DMEM_DEPTH 2048
`define SRPC_LINK_REG 4'hf
`define SRPC_RESET_PC 12'h000
`define SRPC_VEC_LINE0 12'h002
`define SRPC_VEC_LINE1 12'h003
`define SRPC_VEC_LINE2 12'h004
`define SRPC_RET_FIELD 6'h3f
`define SRPC_MODE_FIELD 4'h0
`define SRPC_IO_PAGE 7'h7f
// ----------------------------------------
// Bus map
// ----------------------------------------
`define SRPC_WB_CTRL 16'h0000
`define SRPC_WB_STATUS 16'h0004
`define SRPC_WB_PMEM_BIT 14
`define SRPC_CTRL_RUN_BIT 0
`define SRPC_ST_MODE_BIT 17
`define SRPC_ST_IE_BIT 16
`endif

// ===== logic/srpc_core.v
`timescale 1ns/1ps
`include "srpc_map.vh"

// Operation
// - Split instruction into op, d, b, last
// - Sixteen 32-bit registers per mode
// - Data memory 2048 words, program 4096
// - Codes 0-9 are the register operations
// - Code 8 loads 10-bit literal
// - Codes 12/13 load and store word
// - Code 14 branches relative when condition holds
// - Code 15 links PC, branches 12-bit offset
// - Code 10 conditional link jump, 11 jump
// - Condition field selects tested flag expression
// - Codes 0-9 set N,Z; add/sub set C,V
// - Rotate sets C to result bit 0
// - N is bit 31, Z all zero
// - Three active-high request lines, held by sources
// - Interrupt entry selects interrupt register bank
// - Entry saves PC and flags in R15
// - Entry vectors to 2,3,4, disables interrupts
// - Jump with 111111 returns from interrupt
// - Jump with 0000me sets mode and enable
// - Reset clears mode, enable and PC
// - Conditional link jump to literal is trap
// - I/O address, strobe, out and in buses
module srpc_core (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_interrupt_request_line_zero,
  input wire i_interrupt_request_line_one,
  input wire i_interrupt_request_line_two,
  input wire [31:0] i_io_data,
  output reg [4:0] o_io_addr,
  output reg o_io_write,
  output reg [31:0] o_io_data,
  output reg o_mode,
  output reg o_interrupt_enable_flag,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [15:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack
);

  // Sequencer states: fetch or interrupt entry, execute, and the
  // extra write-back cycle that a data memory load needs because
  // the memory read is registered
  localparam ST_FETCH = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_LOAD = 2'h2;

  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  function cond_ok;
    input [3:0] code;
    input [3:0] f;
    reg n, z, c, v, s;
    begin
      n = f[3];
      z = f[2];
      c = f[1];
      v = f[0];
      s = n ^ v;
      case (code)
        4'h0: cond_ok = z;
        4'h1: cond_ok = ~z;
        4'h2: cond_ok = c;
        4'h3: cond_ok = ~c;
        4'h4: cond_ok = n;
        4'h5: cond_ok = ~n;
        4'h6: cond_ok = v;
        4'h7: cond_ok = ~v;
        4'h8: cond_ok = c & ~z;
        4'h9: cond_ok = ~c | z;
        4'ha: cond_ok = ~s;
        4'hb: cond_ok = s;
        4'hc: cond_ok = ~(s | z);
        4'hd: cond_ok = s | z;
        4'he: cond_ok = 1'b0;
        default: cond_ok = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Interrupt vector selection
  // ----------------------------------------
  // Line 0 wins over line 1, line 1 over line 2
  function [`SRPC_PC_W-1:0] irq_vector;
    input [2:0] lines;
    begin
      if (lines[0]) begin
        irq_vector = `SRPC_VEC_LINE0;
      end else if (lines[1]) begin
        irq_vector = `SRPC_VEC_LINE1;
      end else begin
        irq_vector = `SRPC_VEC_LINE2;
      end
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Entries 0-15 form the normal bank, 16-31 the interrupt bank;
  // the mode bit is the top bit of every register index except the interrupt entry save to R15, which always uses 1.
  // Register file and memories are not cleared by reset.
  reg [31:0] rf [0:31];
  reg [17:0] pmem [0:`SRPC_PMEM_DEPTH-1];
  reg [31:0] dmem [0:`SRPC_DMEM_DEPTH-1];
  reg [1:0] state;
  reg [`SRPC_PC_W-1:0] pc;
  reg [3:0] flags;
  reg [17:0] instr;
  reg [31:0] load_data;
  reg [4:0] load_idx;
  reg run;
  wire [2:0] irq_sync;
  // Request pins, line 0 in bit 0
  wire [2:0] irq_pins = {i_interrupt_request_line_two, i_interrupt_request_line_one,
                         i_interrupt_request_line_zero};
  reg [31:0] in_meta;
  reg [31:0] in_sync;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      in_meta <= 32'h0;
      in_sync <= 32'h0;
    end else begin
      in_meta <= i_io_data;
      in_sync <= in_meta;
    end
  end

  // Two flops per request line; only the second one is read
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq_sync
      reg meta;
      reg sync;
      always @(posedge i_clock) begin
        if (!i_reset_n) begin
          meta <= 1'b0;
          sync <= 1'b0;
        end else begin
          meta <= irq_pins[gi];
          sync <= meta;
        end
      end
      assign irq_sync[gi] = sync;
    end
  endgenerate

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire [3:0] f_op = instr[17:14];
  wire [3:0] f_d = instr[13:10];
  wire [3:0] f_b = instr[9:6];
  wire [5:0] f_a = instr[5:0];
  wire [4:0] idx_d = {o_mode, f_d};
  wire [4:0] idx_b = {o_mode, f_b};
  wire [4:0] idx_a = {o_mode, f_a[3:0]};
  wire [4:0] idx_link = {o_mode, `SRPC_LINK_REG};
  wire [31:0] val_d = rf[idx_d];
  wire [31:0] val_b = rf[idx_b];
  wire [31:0] val_a = rf[idx_a];
  wire [31:0] val_link = rf[idx_link];
  // Last operand: register or 5-bit constant
  wire [31:0] opnd = f_a[5] ? val_a : {27'h0, f_a[4:0]};

  // ----------------------------------------
  // Arithmetic and address paths
  // ----------------------------------------
  wire [32:0] sum = {1'b0, val_b} + {1'b0, opnd};
  wire [32:0] diff = {1'b0, val_b} + {1'b0, ~opnd} + 33'h1;
  wire [63:0] prod = val_b * opnd;
  wire [63:0] rot = {val_b, val_b} >> opnd[4:0];
  wire [31:0] eff_addr = val_b + opnd;
  wire is_io = (eff_addr[11:5] == `SRPC_IO_PAGE);
  wire [`SRPC_DADDR_W-1:0] dm_idx = eff_addr[`SRPC_DADDR_W-1:0];
  wire [`SRPC_PC_W-1:0] cb_target = pc + {{2{instr[9]}}, instr[9:0]};
  wire [`SRPC_PC_W-1:0] bl_target = pc + instr[11:0];
  wire take = cond_ok(f_d, flags);
  wire irq_any = |irq_sync;

  reg [31:0] res;
  reg next_c;
  reg next_v;

  // ALU result and carry/overflow
  always @* begin
    res = 32'h0;
    next_c = flags[1];
    next_v = flags[0];
    case (f_op)
      `SRPC_OP_AND: res = val_b & opnd;
      `SRPC_OP_BIT_CLEAR: res = val_b & ~opnd;
      `SRPC_OP_OR: res = val_b | opnd;
      `SRPC_OP_XOR: res = val_b ^ opnd;
      `SRPC_OP_ADD: begin
        res = sum[31:0];
        next_c = sum[32];
        next_v = (val_b[31] == opnd[31]) & (res[31] != val_b[31]);
      end
      `SRPC_OP_SUB: begin
        res = diff[31:0];
        next_c = diff[32];
        next_v = (val_b[31] != opnd[31]) & (res[31] != val_b[31]);
      end
      `SRPC_OP_MUL: res = prod[31:0];
      `SRPC_OP_INVERT: res = ~opnd;
      `SRPC_OP_LITERAL: res = {22'h0, instr[9:0]};
      `SRPC_OP_ROTATE: begin
        res = rot[31:0];
        next_c = rot[0];
      end
      default: res = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Sequencer and execution
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= ST_FETCH;
      pc <= `SRPC_RESET_PC;
      o_mode <= 1'b0;
      o_interrupt_enable_flag <= 1'b0;
      flags <= 4'h0;
      instr <= 18'h0;
      load_data <= 32'h0;
      load_idx <= 5'h0;
      o_io_addr <= 5'h0;
      o_io_write <= 1'b0;
      o_io_data <= 32'h0;
    end else begin
      o_io_write <= 1'b0;
      case (state)
        ST_FETCH: begin
          if (run && o_interrupt_enable_flag && irq_any) begin
            rf[{1'b1, `SRPC_LINK_REG}] <= {flags, 16'h0, pc};
            o_mode <= 1'b1;
            o_interrupt_enable_flag <= 1'b0;
            pc <= irq_vector(irq_sync);
          end else if (run) begin
            instr <= pmem[pc];
            pc <= pc + 12'h001;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_FETCH;
          case (f_op)
            `SRPC_OP_COND_REG_LINK: begin
              if (take) begin
                rf[idx_link] <= {20'h0, pc};
                pc <= f_a[5] ? val_a[11:0] : {7'h0, f_a[4:0]};
              end
            end
            `SRPC_OP_REG_JUMP: begin
              if (f_a == `SRPC_RET_FIELD) begin
                pc <= val_link[11:0];
                flags <= val_link[31:28];
                o_mode <= 1'b0;
                o_interrupt_enable_flag <= 1'b1;
              end else if (f_a[5:2] == `SRPC_MODE_FIELD) begin
                o_mode <= f_a[1];
                o_interrupt_enable_flag <= f_a[0];
              end else begin
                pc <= val_a[11:0];
              end
            end
            `SRPC_OP_LOAD: begin
              if (is_io) begin
                o_io_addr <= eff_addr[4:0];
                rf[idx_d] <= in_sync;
              end else begin
                load_data <= dmem[dm_idx];
                load_idx <= idx_d;
                state <= ST_LOAD;
              end
            end
            `SRPC_OP_STORE: begin
              if (is_io) begin
                o_io_addr <= eff_addr[4:0];
                o_io_data <= val_d;
                o_io_write <= 1'b1;
              end else begin
                dmem[dm_idx] <= val_d;
              end
            end
            `SRPC_OP_COND_BRANCH: begin
              if (take) begin
                pc <= cb_target;
              end
            end
            `SRPC_OP_BRANCH_LINK: begin
              rf[idx_link] <= {20'h0, pc};
              pc <= bl_target;
            end
            default: begin
              rf[idx_d] <= res;
              flags <= {res[31], (res == 32'h0), next_c, next_v};
            end
          endcase
        end
        ST_LOAD: begin
          rf[load_idx] <= load_data;
          state <= ST_FETCH;
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // A request is taken only while ack is low, so a master that
  // still holds cyc and stb in the ack cycle is not served twice
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_pmem = i_wb_adr[`SRPC_WB_PMEM_BIT];
  wire [11:0] wb_pidx = i_wb_adr[13:2];

  // One-wait-state answer, program load and control
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      run <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && i_wb_we) begin
        if (wb_pmem && (i_wb_sel == 4'hf)) begin
          pmem[wb_pidx] <= i_wb_dat[17:0];
        end else if (!wb_pmem && (i_wb_adr == `SRPC_WB_CTRL) && i_wb_sel[0]) begin
          run <= i_wb_dat[`SRPC_CTRL_RUN_BIT];
        end
      end
      if (wb_req && !i_wb_we) begin
        if (wb_pmem) begin
          o_wb_dat <= {14'h0, pmem[wb_pidx]};
        end else if (i_wb_adr == `SRPC_WB_CTRL) begin
          o_wb_dat <= {31'h0, run};
        end else if (i_wb_adr == `SRPC_WB_STATUS) begin
          o_wb_dat <= {flags, 10'h0, o_mode, o_interrupt_enable_flag, 4'h0, pc};
        end else begin
          o_wb_dat <= 32'h0;
        end
      end
    end
  end

endmodule // srpc_core

// ===== verif/srpc_props.sv
`timescale 1ns/1ps
module srpc_props (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_interrupt_request_line_zero,
  input wire i_interrupt_request_line_one,
  input wire i_interrupt_request_line_two,
  input wire [31:0] i_io_data,
  input wire [4:0] o_io_addr,
  input wire o_io_write,
  input wire [31:0] o_io_data,
  input wire o_mode,
  input wire o_interrupt_enable_flag,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [15:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------
  // Bus steps
  // ----------------------------------------
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd_status;
    s_req ##0 (!i_wb_we && i_wb_adr == 16'h0004);
  endsequence
  sequence s_rd_hole;
    s_req ##0 (!i_wb_we && i_wb_adr == 16'h0100);
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ack_next: assert property (s_req |=> o_wb_ack) else $error("bus answer late");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("bus answer held");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("answer without request");
  a_status_bits: assert property (
    s_rd_status |=> o_wb_dat[17:16] == $past({o_mode, o_interrupt_enable_flag})) else $error("status bits wrong");
  a_hole_zero: assert property (s_rd_hole |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  a_io_pulse: assert property (o_io_write |=> !o_io_write) else $error("strobe too long");
  a_io_hold: assert property (!o_io_write |-> $stable(o_io_data)) else $error("output bus moved");
  a_reset_clear: assert property (disable iff (1'b0) !i_reset_n |=>
    !o_mode && !o_interrupt_enable_flag && !o_io_write && !o_wb_ack) else $error("reset state wrong");
endmodule // srpc_props

// ===== verif/srpc_far_end.sv
`timescale 1ns/1ps
module srpc_far_end #(
  parameter logic [31:0] IN_WORD = 32'h0badc0de
) (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_raise,
  input wire [4:0] i_io_addr,
  input wire i_io_write,
  input wire [31:0] i_io_data,
  output logic o_line0,
  output logic o_line1,
  output logic o_line2,
  output logic [31:0] o_io_data
);
  logic [31:0] last [0:31];
  int hits [0:31];
  // Spare lines idle, input bus steady
  assign o_line0 = 1'b0;
  assign o_line1 = 1'b0;
  assign o_io_data = IN_WORD;
  // Capture on strobe, request held until port 7 served
  always @(posedge i_clock) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 32; i++) hits[i] <= 0;
      o_line2 <= 1'b0;
    end else begin
      if (i_io_write) begin
        last[i_io_addr] <= i_io_data;
        hits[i_io_addr] <= hits[i_io_addr] + 1;
      end
      if (i_io_write && i_io_addr == 5'h07) o_line2 <= 1'b0;
      else if (i_raise) o_line2 <= 1'b1;
    end
  end
endmodule // srpc_far_end

// ===== verif/srpc_core_test.sv
`timescale 1ns/1ps
module srpc_core_test;
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0, raise = 1'b0;
  logic [15:0] i_wb_adr = 16'h0;
  logic [31:0] i_wb_dat = 32'h0, rd;
  logic [3:0] i_wb_sel = 4'h0;
  wire i_interrupt_request_line_zero, i_interrupt_request_line_one, i_interrupt_request_line_two;
  wire o_io_write, o_mode, o_interrupt_enable_flag, o_wb_ack;
  wire [4:0] o_io_addr;
  wire [31:0] i_io_data, o_io_data, o_wb_dat;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [17:0] prog [0:28];
  always #20 i_clock = ~i_clock;
  srpc_core i_dut (.i_clock, .i_reset_n, .i_interrupt_request_line_zero, .i_interrupt_request_line_one,
    .i_interrupt_request_line_two, .i_io_data, .o_io_addr, .o_io_write, .o_io_data, .o_mode,
    .o_interrupt_enable_flag, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack);
  srpc_far_end i_far (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_raise(raise), .i_io_addr(o_io_addr),
    .i_io_write(o_io_write), .i_io_data(o_io_data), .o_line0(i_interrupt_request_line_zero),
    .o_line1(i_interrupt_request_line_one), .o_line2(i_interrupt_request_line_two), .o_io_data(i_io_data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [17:0] ins(input logic [3:0] op, d, b, input logic [5:0] a);
    return {op, d, b, a};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat);
    int n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    i_wb_sel <= 4'hf;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we <= 1'b0;
    @(posedge i_clock);
  endtask
  // Wait for mode and enable, or for a port write
  task automatic wait_for(input logic [1:0] want, input int port);
    int n = 0;
    while (((port < 0) ? ({o_mode, o_interrupt_enable_flag} !== want) : (i_far.hits[port] == 0)) && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
    if (n >= 2000) n_mismatch++;
    @(posedge i_clock);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset_state;
    wb(1'b0, 16'h0004, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 16'h0100, 32'hffffffff);
    wb(1'b0, 16'h0100, 32'h0);
    check(rd, 32'h0);
  endtask
  task t_load_run;
    for (int i = 0; i < 29; i++) prog[i] = 18'h0;
    prog[0] = ins(4'hf, 4'h0, 4'h0, 6'h09);
    prog[4] = ins(4'h7, 4'h1, 4'h0, 6'h1f); prog[5] = ins(4'h8, 4'h3, 4'h5, 6'h15);
    prog[6] = ins(4'hd, 4'h3, 4'h1, 6'h07); prog[9] = ins(4'hb, 4'h0, 4'h0, 6'h3f);
    prog[10] = ins(4'h7, 4'h1, 4'h0, 6'h1f); prog[11] = ins(4'h8, 4'h2, 4'hf, 6'h3f);
    prog[12] = ins(4'h4, 4'h3, 4'h2, 6'h01); prog[13] = ins(4'hd, 4'h3, 4'h1, 6'h01);
    prog[14] = ins(4'h9, 4'h4, 4'h2, 6'h04); prog[15] = ins(4'hd, 4'h4, 4'h1, 6'h02);
    prog[16] = ins(4'h5, 4'h5, 4'h2, 6'h22); prog[17] = ins(4'he, 4'h0, 4'h0, 6'h01);
    prog[18] = ins(4'hd, 4'h2, 4'h1, 6'h03); prog[19] = ins(4'h1, 4'h6, 4'h2, 6'h0f);
    prog[20] = ins(4'hd, 4'h6, 4'h1, 6'h04); prog[21] = ins(4'h6, 4'h7, 4'h2, 6'h22);
    prog[22] = ins(4'hd, 4'h7, 4'h1, 6'h05); prog[23] = ins(4'hc, 4'h8, 4'h1, 6'h08);
    prog[24] = ins(4'hd, 4'h8, 4'h1, 6'h09); prog[25] = ins(4'he, 4'he, 4'h0, 6'h01);
    prog[26] = ins(4'hd, 4'h2, 4'h1, 6'h06); prog[27] = ins(4'hb, 4'h0, 4'h0, 6'h01);
    prog[28] = ins(4'he, 4'hf, 4'hf, 6'h3f);
    for (int i = 0; i < 29; i++) wb(1'b1, 16'h4000 | 16'(i * 4), {14'h0, prog[i]});
    wb(1'b0, 16'h4000 | 16'(17 * 4), 32'h0);
    check(rd, {14'h0, prog[17]});
    wb(1'b1, 16'h0000, 32'h1);
  endtask
  task t_alu;
    wait_for(2'b00, 6);
    check(i_far.last[1], 32'h3ff + 32'h1);
    check(i_far.last[2], (32'h3ff >> 4) | (32'h3ff << 28));
    check(i_far.last[4], 32'h3ff & ~32'hf);
    check(i_far.last[5], 32'h3ff * 32'h3ff);
    check(i_far.last[9], 32'h0badc0de);
    check(i_far.hits[3], 32'h0);
    check(i_far.last[6], 32'h3ff);
  endtask
  task t_irq;
    wait_for(2'b01, -1);
    wb(1'b0, 16'h0004, 32'h0);
    check(rd & 32'hf0030000, 32'h20010000);
    raise <= 1'b1;
    @(posedge i_clock);
    raise <= 1'b0;
    wait_for(2'b10, -1);
    check(i_interrupt_request_line_two, 1'b1);
    wait_for(2'b01, -1);
    check(i_far.last[7], 32'h155);
    check(i_far.hits[7], 32'h1);
    wb(1'b0, 16'h0004, 32'h0);
    check(rd & 32'hf0030000, 32'h20010000);
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    t_reset_state;
    t_load_run;
    t_alu;
    t_irq;
    end_sim;
  end
  // Watchdog
  initial begin
    #800000;
    n_mismatch++;
    end_sim;
  end
endmodule // srpc_core_test
bind srpc_core srpc_props i_props (.i_clock, .i_reset_n, .i_interrupt_request_line_zero,
  .i_interrupt_request_line_one, .i_interrupt_request_line_two, .i_io_data, .o_io_addr, .o_io_write,
  .o_io_data, .o_mode, .o_interrupt_enable_flag, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
  .i_wb_sel, .o_wb_dat, .o_wb_ack);
